// file: logic/lps_pkg.sv
// constants shared by the line performance status message builder
// Notes on behaviour
// - network message starts with identifier 140
// - customer message starts with identifier 141
// - customer message uses identical octet layout
// - octet 2 bits 3,2,1 carry alarms
// - octet 2 bit 6 is backoff status
// - octet 2 bit 5 is device fault
// - octet 2 bit 4 is continuity fault
// - octet 3 signed margin, 127 not available
// - octet 4 attenuation, -128 not available
// - octets 5,6,9,10 wrap modulo 256
// - octets 7-8 CRC count modulo 65536
// - octet 11 bits 7,5 overflow since response
// - octet 11 bits 6,4 counter reset seen
// - response to central clears bits 7,6
// - response to remote clears bits 5,4
// - octet 11 bits 3..0 backoff base
// - octet 12 bit 7 adds 16 dB
// - full poll sends both plus maintenance
// - ordinary poll sends only sides with device fault, alarm or change
package lps_pkg;
	localparam logic [7:0]  LPS_ID_NET    = 8'h8C;
	localparam logic [7:0]  LPS_ID_CUS    = 8'h8D;
	localparam logic [7:0]  LPS_SNR_NA    = 8'h7F;
	localparam logic [7:0]  LPS_ATT_NA    = 8'h80;
	localparam int          LPS_MSG_LEN   = 12;
	localparam logic [3:0]  LPS_LAST_IDX  = 4'hB;
	// register byte offsets
	localparam logic [7:0]  LPS_OFF_CTRL  = 8'h00;
	localparam logic [7:0]  LPS_OFF_STAT  = 8'h04;
	localparam logic [7:0]  LPS_OFF_MEASN = 8'h08;
	localparam logic [7:0]  LPS_OFF_MEASC = 8'h0C;
	localparam logic [7:0]  LPS_OFF_CNTN  = 8'h10;
	localparam logic [7:0]  LPS_OFF_CNTC  = 8'h14;
	localparam logic [7:0]  LPS_OFF_CRC   = 8'h18;
	// measurement register fields
	localparam int          LPS_M_SNR     = 0;
	localparam int          LPS_M_ATT     = 8;
	localparam int          LPS_M_BASE    = 16;
	localparam int          LPS_M_EXT     = 20;
	localparam int          LPS_M_SEL     = 21;
	// control register fields
	localparam int          LPS_C_LOOP    = 0;
	localparam int          LPS_C_CLR     = 8;
	localparam logic [31:0] LPS_MEAS_RST  = 32'h0000_807F;
	localparam logic [31:0] LPS_CTRL_RST  = 32'h0000_0001;
	// sticky flag order {ovf central, rst central, ovf remote, rst remote}
	localparam logic [3:0]  LPS_FLAG_RST  = 4'h5;
	typedef enum logic [1:0] {
		LPS_IDLE = 2'b00,
		LPS_LOAD = 2'b01,
		LPS_SEND = 2'b10
	} lps_state_t;
endpackage : lps_pkg

// file: logic/lps_wrap_cnt.sv
// modulo counter with wrap pulse
`timescale 1ns/1ps
module lps_wrap_cnt #(
	parameter int W = 8
) (
	input  wire logic         ref_clk, // clock
	input  wire logic         reset,   // sync reset
	input  wire logic         clr,     // restart from zero
	input  wire logic         inc,     // count one
	output logic [W-1:0]      count,   // current count
	output logic              wrap     // pulse on wrap
);
	assign wrap = inc & ~clr & (&count);
	always_ff @(posedge ref_clk) begin
		if (reset || clr) begin
			count <= '0;
		end else if (inc) begin
			count <= count + 1'b1;
		end
	end
	chk_wrap_to_zero: assert property (@(posedge ref_clk) disable iff (reset)
		wrap |=> count == '0) else $error("counter did not wrap to zero");
endmodule : lps_wrap_cnt

// file: logic/lps_side_stats.sv
// per-side modulo counters and sticky overflow and reset indications
`timescale 1ns/1ps
module lps_side_stats
	import lps_pkg::*;
(
	input  wire logic        ref_clk,   // clock
	input  wire logic        reset,     // sync reset
	input  wire logic        cnt_clr,   // clear all counters
	input  wire logic [3:0]  sec_tick,  // {uas, sync_word_loss, ses, es} second events
	input  wire logic        crc_anom,  // crc anomaly event
	input  wire logic        snap,      // message captured
	input  wire logic        clr_cen,   // response sent to central_transceiver
	input  wire logic        clr_rem,   // response sent to remote_transceiver
	output logic [7:0]       sec_cnt [4], // second counters
	output logic [15:0]      crc_cnt,   // crc anomaly counter
	output logic [3:0]       flags      // octet 11 bits 7..4
);
	logic [4:0] wraps;
	logic [3:0] ev;
	logic [3:0] clr;
	logic [3:0] fresh_r;
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_sec
			lps_wrap_cnt #(.W(8)) u_cnt (
				.ref_clk (ref_clk),
				.reset   (reset),
				.clr     (cnt_clr),
				.inc     (sec_tick[g]),
				.count   (sec_cnt[g]),
				.wrap    (wraps[g])
			);
		end
	endgenerate
	lps_wrap_cnt #(.W(16)) u_crc (
		.ref_clk (ref_clk),
		.reset   (reset),
		.clr     (cnt_clr),
		.inc     (crc_anom),
		.count   (crc_cnt),
		.wrap    (wraps[4])
	);
	assign ev  = {|wraps, cnt_clr, |wraps, cnt_clr};
	assign clr = {clr_cen, clr_cen, clr_rem, clr_rem};
	// events after capture must survive the clear that follows the send
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			flags   <= LPS_FLAG_RST;
			fresh_r <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (ev[i]) begin
					flags[i] <= 1'b1;
				end else if (clr[i] && !fresh_r[i]) begin
					flags[i] <= 1'b0;
				end
				fresh_r[i] <= snap ? ev[i] : (fresh_r[i] | ev[i]);
			end
		end
	end
	// no central or remote event since capture, for the clear checks
	logic quiet_cen_r;
	logic quiet_rem_r;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			quiet_cen_r <= 1'b0;
			quiet_rem_r <= 1'b0;
		end else if (snap) begin
			quiet_cen_r <= !(ev[3] || ev[2]);
			quiet_rem_r <= !(ev[1] || ev[0]);
		end else begin
			quiet_cen_r <= quiet_cen_r && !(ev[3] || ev[2]);
			quiet_rem_r <= quiet_rem_r && !(ev[1] || ev[0]);
		end
	end
	chk_ovf_sticky: assert property (@(posedge ref_clk) disable iff (reset)
		(|wraps) |=> flags[3] && flags[1]) else $error("overflow not flagged");
	chk_cen_clear: assert property (@(posedge ref_clk) disable iff (reset)
		quiet_cen_r && !ev[3] && !ev[2] && clr_cen |=> !flags[3] && !flags[2])
		else $error("central flags not cleared");
	chk_rem_clear: assert property (@(posedge ref_clk) disable iff (reset)
		quiet_rem_r && !ev[1] && !ev[0] && clr_rem |=> !flags[1] && !flags[0])
		else $error("remote flags not cleared");
endmodule : lps_side_stats

// file: logic/lps_msg_builder.sv
// line performance status message builder with ahb-lite registers
`timescale 1ns/1ps
module lps_msg_builder
	import lps_pkg::*;
(
	input  wire logic        ref_clk,      // 200 MHz clock
	input  wire logic        reset,        // sync reset, active high
	input  wire logic        hsel,         // ahb select
	input  wire logic [31:0] haddr,        // ahb address
	input  wire logic [1:0]  htrans,       // ahb transfer type
	input  wire logic        hwrite,       // ahb write
	input  wire logic [2:0]  hsize,        // ahb size
	input  wire logic [31:0] hwdata,       // ahb write data
	input  wire logic        hready,       // ahb bus ready
	output logic [31:0]      hrdata,       // ahb read data
	output logic             hreadyout,    // ahb slave ready
	output logic             hresp,        // ahb response
	input  wire logic        dev_fault,    // unit hardware or software fault
	input  wire logic [3:0]  n_alarm,      // network {dc, snr, att, sync_word_loss}
	input  wire logic [3:0]  c_alarm,      // customer {dc, snr, att, sync_word_loss}
	input  wire logic [3:0]  n_sec_tick,   // network {uas, sync_word_loss, ses, es}
	input  wire logic [3:0]  c_sec_tick,   // customer {uas, sync_word_loss, ses, es}
	input  wire logic        n_crc_anom,   // network crc anomaly
	input  wire logic        c_crc_anom,   // customer crc anomaly
	input  wire logic        poll_valid,   // status poll request
	input  wire logic        poll_full,    // full status poll
	input  wire logic        poll_remote,  // poll from remote_transceiver
	output logic             poll_ready,   // poll accepted when high
	output logic             tx_valid,     // octet valid
	output logic [7:0]       tx_octet,     // message octet
	output logic             tx_first,     // identifier octet
	output logic             tx_last,      // final octet
	output logic             tx_remote,    // message goes to remote_transceiver
	input  wire logic        tx_ready,     // octet taken
	output logic             maint_req,    // send maintenance status now
	output logic             snr_req       // send status/snr reply instead
);
	lps_state_t  state_r;
	logic [31:0] ctrl_r;
	logic [31:0] meas_r [2];
	logic        cnt_clr_r;
	logic        wr_pend_r;
	logic [7:0]  wr_off_r;
	logic        side_r;
	logic        pend_c_r;
	logic        full_r;
	logic [3:0]  idx_r;
	logic [7:0]  msg_q [LPS_MSG_LEN];
	logic [7:0]  oct [LPS_MSG_LEN];
	logic [1:0]  chg_r;
	logic [3:0]  alarm_prev_r [2];
	logic [7:0]  sec_cnt [2][4];
	logic [15:0] crc_cnt [2];
	logic [3:0]  flags [2];
	logic [31:0] rd_mux;
	logic [1:0]  snap;
	logic [1:0]  clr_cen;
	logic [1:0]  clr_rem;
	logic [1:0]  need;
	logic [1:0]  meas_wr;
	logic        addr_ok;
	logic        poll_take;
	logic        msg_end;
	logic [3:0]  al_sel;
	logic [31:0] m_sel;

	assign addr_ok   = hsel & hready & htrans[1];
	assign poll_take = poll_valid & poll_ready & (state_r == LPS_IDLE);
	assign msg_end   = (state_r == LPS_SEND) & tx_ready & (idx_r == LPS_LAST_IDX);
	assign meas_wr   = {wr_pend_r & (wr_off_r == LPS_OFF_MEASC),
		wr_pend_r & (wr_off_r == LPS_OFF_MEASN)};
	assign need[0]   = dev_fault | (|n_alarm) | chg_r[0];
	assign need[1]   = dev_fault | (|c_alarm) | chg_r[1];

	// ahb-lite slave, zero wait states
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (haddr[31:8] == 24'h00_0000) begin
			case (haddr[7:0])
				LPS_OFF_CTRL:  rd_mux = ctrl_r;
				LPS_OFF_STAT:  rd_mux = {20'h0_0000, flags[1], flags[0], chg_r, state_r};
				LPS_OFF_MEASN: rd_mux = meas_r[0];
				LPS_OFF_MEASC: rd_mux = meas_r[1];
				LPS_OFF_CNTN:  rd_mux = {sec_cnt[0][3], sec_cnt[0][2], sec_cnt[0][1],
					sec_cnt[0][0]};
				LPS_OFF_CNTC:  rd_mux = {sec_cnt[1][3], sec_cnt[1][2], sec_cnt[1][1],
					sec_cnt[1][0]};
				LPS_OFF_CRC:   rd_mux = {crc_cnt[1], crc_cnt[0]};
				default:       rd_mux = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wr_pend_r <= 1'b0;
			wr_off_r  <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wr_pend_r <= addr_ok & hwrite & (haddr[31:8] == 24'h00_0000);
			wr_off_r  <= haddr[7:0];
			hrdata    <= (addr_ok & ~hwrite) ? rd_mux : 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ctrl_r    <= LPS_CTRL_RST;
			meas_r[0] <= LPS_MEAS_RST;
			meas_r[1] <= LPS_MEAS_RST;
			cnt_clr_r <= 1'b0;
		end else begin
			cnt_clr_r <= 1'b0;
			if (wr_pend_r && wr_off_r == LPS_OFF_CTRL) begin
				ctrl_r    <= {30'h0000_0000, hwdata[LPS_C_LOOP +: 2]};
				cnt_clr_r <= hwdata[LPS_C_CLR];
			end
			for (int s = 0; s < 2; s++) begin
				if (meas_wr[s]) begin
					meas_r[s] <= {10'h000, hwdata[21:0]};
				end
			end
		end
	end

	// change tracking since last poll; a new change beats the poll clear
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			chg_r           <= 2'b00;
			alarm_prev_r[0] <= 4'h0;
			alarm_prev_r[1] <= 4'h0;
		end else begin
			alarm_prev_r[0] <= n_alarm;
			alarm_prev_r[1] <= c_alarm;
			for (int s = 0; s < 2; s++) begin
				if ((s == 0 ? (|n_sec_tick | n_crc_anom | (n_alarm != alarm_prev_r[0]))
					: (|c_sec_tick | c_crc_anom | (c_alarm != alarm_prev_r[1])))
					|| (meas_wr[s] && hwdata[21:8] != meas_r[s][21:8])) begin
					chg_r[s] <= 1'b1;
				end else if (poll_take) begin
					chg_r[s] <= 1'b0;
				end
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_side
			assign snap[g]    = (state_r == LPS_LOAD) & (side_r == 1'(g));
			assign clr_cen[g] = msg_end & (side_r == 1'(g)) & ~tx_remote;
			assign clr_rem[g] = msg_end & (side_r == 1'(g)) & tx_remote;
			lps_side_stats u_stats (
				.ref_clk  (ref_clk),
				.reset    (reset),
				.cnt_clr  (cnt_clr_r),
				.sec_tick (g == 0 ? n_sec_tick : c_sec_tick),
				.crc_anom (g == 0 ? n_crc_anom : c_crc_anom),
				.snap     (snap[g]),
				.clr_cen  (clr_cen[g]),
				.clr_rem  (clr_rem[g]),
				.sec_cnt  (sec_cnt[g]),
				.crc_cnt  (crc_cnt[g]),
				.flags    (flags[g])
			);
		end
	endgenerate

	// octet image of the side being captured; both sides share one layout
	always_comb begin
		m_sel   = meas_r[side_r];
		al_sel  = side_r ? c_alarm : n_alarm;
		oct[0]  = side_r ? LPS_ID_CUS : LPS_ID_NET;
		oct[1]  = {1'b0, m_sel[LPS_M_SEL], dev_fault, al_sel, 1'b0};
		oct[2]  = m_sel[LPS_M_SNR +: 8];
		oct[3]  = m_sel[LPS_M_ATT +: 8];
		oct[4]  = sec_cnt[side_r][0];
		oct[5]  = sec_cnt[side_r][1];
		oct[6]  = crc_cnt[side_r][15:8];
		oct[7]  = crc_cnt[side_r][7:0];
		oct[8]  = sec_cnt[side_r][2];
		oct[9]  = sec_cnt[side_r][3];
		oct[10] = {flags[side_r], m_sel[LPS_M_BASE +: 4]};
		oct[11] = {m_sel[LPS_M_EXT], 5'h00, ctrl_r[LPS_C_LOOP +: 2]};
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_r    <= LPS_IDLE;
			side_r     <= 1'b0;
			pend_c_r   <= 1'b0;
			full_r     <= 1'b0;
			idx_r      <= 4'h0;
			poll_ready <= 1'b1;
			tx_valid   <= 1'b0;
			tx_octet   <= 8'h00;
			tx_first   <= 1'b0;
			tx_last    <= 1'b0;
			tx_remote  <= 1'b0;
			maint_req  <= 1'b0;
			snr_req    <= 1'b0;
		end else begin
			maint_req <= 1'b0;
			snr_req   <= 1'b0;
			case (state_r)
				LPS_IDLE: begin
					if (poll_take) begin
						tx_remote <= poll_remote;
						full_r    <= poll_full;
						if (poll_full || need[0]) begin
							side_r     <= 1'b0;
							pend_c_r   <= poll_full | need[1];
							state_r    <= LPS_LOAD;
							poll_ready <= 1'b0;
						end else if (need[1]) begin
							side_r     <= 1'b1;
							pend_c_r   <= 1'b0;
							state_r    <= LPS_LOAD;
							poll_ready <= 1'b0;
						end else begin
							snr_req <= 1'b1;
						end
					end
				end
				LPS_LOAD: begin
					for (int i = 0; i < LPS_MSG_LEN; i++) begin
						msg_q[i] <= oct[i];
					end
					tx_valid <= 1'b1;
					tx_octet <= oct[0];
					tx_first <= 1'b1;
					tx_last  <= 1'b0;
					idx_r    <= 4'h0;
					state_r  <= LPS_SEND;
				end
				LPS_SEND: begin
					if (tx_ready) begin
						if (idx_r == LPS_LAST_IDX) begin
							tx_valid <= 1'b0;
							tx_last  <= 1'b0;
							if (pend_c_r) begin
								side_r   <= 1'b1;
								pend_c_r <= 1'b0;
								state_r  <= LPS_LOAD;
							end else begin
								maint_req  <= full_r;
								poll_ready <= 1'b1;
								state_r    <= LPS_IDLE;
							end
						end else begin
							idx_r    <= idx_r + 4'h1;
							tx_octet <= msg_q[idx_r + 4'h1];
							tx_first <= 1'b0;
							tx_last  <= (idx_r + 4'h1) == LPS_LAST_IDX;
						end
					end
				end
				default: begin
					state_r <= LPS_IDLE;
				end
			endcase
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	// octets accepted in the current message, for the length check
	logic [3:0] n_taken_r;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			n_taken_r <= 4'h0;
		end else if (tx_valid && tx_ready) begin
			n_taken_r <= tx_last ? 4'h0 : n_taken_r + 4'h1;
		end
	end

	chk_net_id: assert property (
		tx_valid && tx_first && !side_r |-> tx_octet == LPS_ID_NET)
		else $error("network message id wrong");
	chk_cus_id: assert property (
		tx_valid && tx_first && side_r |-> tx_octet == LPS_ID_CUS)
		else $error("customer message id wrong");
	chk_msg_length: assert property (
		tx_valid && tx_last |-> n_taken_r == LPS_LAST_IDX)
		else $error("message length wrong");
	chk_oct2_rsvd: assert property (
		tx_valid && idx_r == 4'h1 |-> tx_octet[7] == 1'b0 && tx_octet[0] == 1'b0)
		else $error("octet 2 reserved set");
	chk_oct12_rsvd: assert property (
		tx_valid && tx_last |-> tx_octet[6:2] == 5'h00)
		else $error("octet 12 reserved set");
	chk_full_order: assert property (
		poll_take && poll_full |=> side_r == 1'b0 && pend_c_r ##1 tx_valid && tx_first)
		else $error("full poll not started");
	chk_maint_full: assert property (
		maint_req |-> full_r && state_r == LPS_IDLE)
		else $error("maintenance on ordinary poll");
	chk_quiet_poll: assert property (
		poll_take && !poll_full && !need[0] && !need[1] |=> snr_req && state_r == LPS_IDLE)
		else $error("quiet poll mishandled");
	chk_stream_hold: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_octet))
		else $error("octet dropped under back-pressure");
	chk_flag_octet: assert property (
		state_r == LPS_LOAD |=> msg_q[10][7:4] == $past(flags[side_r]))
		else $error("octet 11 flags not captured");
	cov_full_poll: cover property (poll_take && poll_full ##[1:200] maint_req);
	cov_quiet_poll: cover property (snr_req);
	cov_backpressure: cover property (tx_valid && !tx_ready);
	cov_customer_msg: cover property (tx_valid && tx_first && side_r);
endmodule : lps_msg_builder

// file: sim/lps_poll_partner.sv
// polling management entity model: raises polls and sinks message octets
`timescale 1ns/1ps
module lps_poll_partner (
	input  wire logic       ref_clk,     // clock
	input  wire logic       poll_ready,  // poll accepted when high
	input  wire logic       tx_valid,    // octet valid
	input  wire logic [7:0] tx_octet,    // message octet
	input  wire logic       tx_first,    // identifier octet
	input  wire logic       tx_last,     // final octet
	input  wire logic       tx_remote,   // message direction
	input  wire logic       snr_req,     // nothing to report
	input  wire logic       maint_req,   // maintenance follows
	output logic            poll_valid,  // poll request
	output logic            poll_full,   // full poll
	output logic            poll_remote, // poll from remote side
	output logic            tx_ready     // octet taken
);
	logic [7:0] q [$];
	int         n_first = 0;
	int         n_last = 0;
	int         n_snr = 0;
	int         n_maint = 0;
	int         n_dir = 0;
	logic       slow = 1'b0;
	initial begin
		poll_valid = 1'b0;
		poll_full = 1'b0;
		poll_remote = 1'b0;
		tx_ready = 1'b0;
	end
	// slow mode takes an octet only every other cycle
	always @(posedge ref_clk) begin
		tx_ready <= slow ? ~tx_ready : 1'b1;
		if (tx_valid === 1'b1 && tx_ready) begin
			q.push_back(tx_octet);
			n_first += (tx_first === 1'b1);
			n_last += (tx_last === 1'b1);
			n_dir += (tx_remote !== poll_remote);
		end
		n_snr += (snr_req === 1'b1);
		n_maint += (maint_req === 1'b1);
	end
	// a poll is raised only while ready and dropped once taken
	task poll(input logic full, input logic remote);
		q.delete();
		n_first = 0;
		n_last = 0;
		n_snr = 0;
		n_maint = 0;
		n_dir = 0;
		while (poll_ready !== 1'b1) @(posedge ref_clk);
		poll_valid <= 1'b1;
		poll_full <= full;
		poll_remote <= remote;
		@(posedge ref_clk);
		poll_valid <= 1'b0;
		repeat (3) @(posedge ref_clk);
		for (int i = 0; i < 400 && !(poll_ready === 1'b1 && tx_valid === 1'b0); i++)
			@(posedge ref_clk);
		// second edge lets the counting process see the closing pulse
		repeat (2) @(posedge ref_clk);
	endtask : poll
endmodule : lps_poll_partner

// file: sim/lps_msg_builder_bench.sv
// self-checking bench for the status message builder
`timescale 1ns/1ps
module lps_msg_builder_bench;
	import lps_pkg::*;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        dev_fault = 1'b0;
	logic [3:0]  n_alarm = 4'h0;
	logic [3:0]  c_alarm = 4'h0;
	logic [3:0]  n_sec_tick = 4'h0;
	logic [3:0]  c_sec_tick = 4'h0;
	logic        n_crc_anom = 1'b0;
	logic        c_crc_anom = 1'b0;
	logic        poll_valid;
	logic        poll_full;
	logic        poll_remote;
	logic        poll_ready;
	logic        tx_valid;
	logic [7:0]  tx_octet;
	logic        tx_first;
	logic        tx_last;
	logic        tx_remote;
	logic        tx_ready;
	logic        maint_req;
	logic        snr_req;
	int          n_fail = 0;
	int          compares = 0;
	int          cyc = 0;

	always #2.5 ref_clk = ~ref_clk;

	lps_msg_builder i_dut (.*, .hsize(3'b010), .hready(hreadyout));
	lps_poll_partner i_peer (.*);

	task results;
		$display("counts: %0d mismatches, %0d compares", n_fail, compares);
		if (n_fail == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			$display("mismatch %0t run did not complete", $time);
			results();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		r = hrdata;
		chk(hresp, 1'b0, "response");
	endtask : ahb

	task wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask : wr

	task rd(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0000_0000, r);
		chk(r, exp, "register read");
	endtask : rd

	// k separated pulses on the chosen event inputs
	task pulse(input logic [3:0] nt, input logic [3:0] ct, input logic nc, input int k);
		repeat (k) begin
			n_sec_tick <= nt;
			c_sec_tick <= ct;
			n_crc_anom <= nc;
			@(posedge ref_clk);
			n_sec_tick <= 4'h0;
			c_sec_tick <= 4'h0;
			n_crc_anom <= 1'b0;
			@(posedge ref_clk);
		end
	endtask : pulse

	task done(input int octs, input int msgs, input int maint);
		chk(i_peer.q.size(), octs, "octet count");
		chk(i_peer.n_first, msgs, "first marks");
		chk(i_peer.n_last, msgs, "last marks");
		chk(i_peer.n_maint, maint, "maintenance pulses");
		chk(i_peer.n_dir, 0, "direction");
	endtask : done

	task msg(input int base, input logic [7:0] e [12]);
		for (int i = 0; i < 12; i++)
			chk(i_peer.q[base+i], e[i], "message octet");
	endtask : msg

	task t_reset;
		chk(poll_ready, 1'b1, "poll ready");
		rd(LPS_OFF_CTRL, 32'h0000_0001);
		rd(LPS_OFF_STAT, 32'h0000_0550);
		rd(LPS_OFF_MEASN, 32'h0000_807F);
		rd(LPS_OFF_MEASC, 32'h0000_807F);
		wr(LPS_OFF_CRC, 32'hFFFF_FFFF);
		rd(LPS_OFF_CRC, 32'h0000_0000);
		rd(32'h0000_001C, 32'h0000_0000);
		rd(32'h0000_0108, 32'h0000_0000);
	endtask : t_reset

	task t_full_first;
		i_peer.poll(1'b1, 1'b0);
		done(24, 2, 1);
		msg(0, '{8'h8C, 8'h00, 8'h7F, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h50, 8'h01});
		msg(12, '{8'h8D, 8'h00, 8'h7F, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h50, 8'h01});
	endtask : t_full_first

	task t_fields;
		wr(LPS_OFF_MEASN, 32'h003A_1205);
		wr(LPS_OFF_CTRL, 32'h0000_0002);
		n_alarm <= 4'hF;
		c_alarm <= 4'h5;
		dev_fault <= 1'b1;
		pulse(4'h1, 4'h0, 1'b0, 3);
		pulse(4'h0, 4'h0, 1'b1, 2);
		i_peer.slow = 1'b1;
		i_peer.poll(1'b1, 1'b1);
		i_peer.slow = 1'b0;
		done(24, 2, 1);
		msg(0, '{8'h8C, 8'h7E, 8'h05, 8'h12, 8'h03, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h1A, 8'h82});
		msg(12, '{8'h8D, 8'h2A, 8'h7F, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h02});
	endtask : t_fields

	task t_ordinary;
		n_alarm <= 4'h0;
		c_alarm <= 4'h0;
		dev_fault <= 1'b0;
		@(posedge ref_clk);
		i_peer.poll(1'b0, 1'b0);
		done(24, 2, 0);
		i_peer.poll(1'b0, 1'b0);
		chk(i_peer.q.size(), 0, "quiet poll octets");
		chk(i_peer.n_snr, 1, "quiet poll reply");
		pulse(4'h0, 4'h1, 1'b0, 1);
		i_peer.poll(1'b0, 1'b0);
		done(12, 1, 0);
		msg(0, '{8'h8D, 8'h00, 8'h7F, 8'h80, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02});
	endtask : t_ordinary

	task t_overflow;
		pulse(4'h1, 4'h0, 1'b0, 257);
		rd(LPS_OFF_CNTN, 32'h0000_0004);
		rd(LPS_OFF_CRC, 32'h0000_0002);
		i_peer.poll(1'b1, 1'b0);
		msg(0, '{8'h8C, 8'h40, 8'h05, 8'h12, 8'h04, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'hAA, 8'h82});
		wr(LPS_OFF_CTRL, 32'h0000_0102);
		i_peer.poll(1'b1, 1'b1);
		done(24, 2, 1);
		msg(0, '{8'h8C, 8'h40, 8'h05, 8'h12, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h7A, 8'h82});
		msg(12, '{8'h8D, 8'h00, 8'h7F, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h50, 8'h02});
	endtask : t_overflow

	initial begin
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		t_reset();
		t_full_first();
		t_fields();
		t_ordinary();
		t_overflow();
		results();
	end
endmodule : lps_msg_builder_bench
